/* File: flash_dev_end.sv */
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
module flash_dev_end #(
  parameter int NUM_BLOCKS  = flash_cmd_pkg::NUM_BLOCKS,
  parameter int BLOCK_BYTES = flash_cmd_pkg::BLOCK_BYTES,
  parameter int ADDR_W      = flash_cmd_pkg::ADDR_W
)(
  input  wire logic              core_clk_in,
  input  wire logic              rst_n_in,
  flash_cmd_if.dev               link,
  output logic                   fl_wr_out,
  output logic      [ADDR_W-1:0] fl_addr_out,
  output logic      [7:0]        fl_data_out,
  input  wire logic              fl_ready_in,
  output logic                   busy_out
);
  import flash_cmd_pkg::*;

  typedef enum logic [2:0] {ST_HDR, ST_ERASE, ST_DATA, ST_REPLY, ST_SEND} dev_state_type;

  localparam logic [ADDR_W-1:0] STORE_END = ADDR_W'(NUM_BLOCKS * BLOCK_BYTES);
  localparam logic [ADDR_W-1:0] BLK_SIZE  = ADDR_W'(BLOCK_BYTES);
  localparam logic [16:0]       SPAN_MAX  = 17'(BLOCK_BYTES);

  dev_state_type     state_r;
  logic              req_ready_r;
  logic              bcast_r;
  logic              last_seen_r;
  logic              wr_ok_r;
  logic              fail_r;
  logic              quiet_r;
  logic              fl_wr_r;
  logic              rsp_valid_r;
  logic              rsp_last_r;
  logic              busy_r;
  logic [7:0]        fl_data_r;
  logic [7:0]        rsp_data_r;
  logic [7:0]        stat_r;
  logic [ADDR_W-1:0] fl_addr_r;
  logic [ADDR_W-1:0] er_addr_r;
  logic [ADDR_W-1:0] er_end_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [15:0]       left_r;
  logic [2:0]        rsp_idx_r;
  logic [HDR_W-1:0]  hdr;
  logic              hdr_full;
  logic              hdr_slot7;
  logic              hdr_clear;
  logic              take;
  logic              rsp_take;
  logic              fl_free;
  logic              er_issue;
  logic              er_done;
  logic              dt_issue;
  logic [7:0]        h_op;
  logic [15:0]       h_blk;
  logic [15:0]       h_idx;
  logic [15:0]       h_cnt;
  logic              d_erase;
  logic              d_wr;
  logic              d_fail;
  logic              d_quiet;
  logic [ADDR_W-1:0] d_base;
  logic [ADDR_W-1:0] d_er_lo;
  logic [ADDR_W-1:0] d_er_hi;

  // the header fields stay in the capture register until the reply is gone
  hdr_capture #(
    .BYTES         (HDR_BYTES)
  ) u_hdr (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .clear_in      (hdr_clear),
    .take_in       (take && state_r == ST_HDR),
    .byte_in       (link.req_data),
    .hdr_out       (hdr),
    .full_out      (hdr_full),
    .slot_last_out (hdr_slot7)
  );

  // field split of the captured header
  assign h_op  = hdr[OPC_LSB +: 8];
  assign h_blk = hdr[BLK_LSB +: 16];
  assign h_idx = hdr[IDX_LSB +: 16];
  assign h_cnt = hdr[CNT_LSB +: 16];

  // handshakes and flash port pacing
  assign take     = link.req_valid && req_ready_r;
  assign rsp_take = rsp_valid_r && link.rsp_ready;
  assign fl_free  = !fl_wr_r || fl_ready_in;
  assign er_issue = (state_r == ST_ERASE) && fl_free && (er_addr_r != er_end_r);
  assign er_done  = (state_r == ST_ERASE) && fl_free && (er_addr_r == er_end_r);
  assign dt_issue = (state_r == ST_DATA) && take && wr_ok_r && (left_r != FIELD_ZERO);

  // a frame ending inside the header is dropped without a reply
  assign hdr_clear = ((state_r == ST_HDR) && take && link.req_last && !hdr_slot7) ||
                     ((state_r == ST_REPLY) && !fl_wr_r && quiet_r) ||
                     (rsp_take && rsp_last_r);

  // command decode, evaluated while the full header sits in the capture register
  always_comb
  begin
    d_base  = ADDR_W'(32'(h_blk) * BLOCK_BYTES);
    d_erase = 1'b0;
    d_wr    = 1'b0;
    d_fail  = 1'b0;
    d_quiet = bcast_r;
    d_er_lo = '0;
    d_er_hi = STORE_END;
    case (h_op)
      OP_CLEAR:
      begin
        if (h_cnt == FIELD_ZERO)
          d_erase = 1'b1;
        else if (32'(h_blk) < NUM_BLOCKS)
        begin
          d_erase = 1'b1;
          d_er_lo = d_base;
          d_er_hi = d_base + BLK_SIZE;
        end
        else
          d_fail = 1'b1;
      end
      OP_PROG, OP_CLEAR_PROG:
      begin
        if (h_cnt == FIELD_ZERO)
          d_erase = 1'b1;
        else if ((32'(h_blk) < NUM_BLOCKS) && (17'(h_idx) + 17'(h_cnt) <= SPAN_MAX))
        begin
          d_wr = 1'b1;
          if (h_op == OP_CLEAR_PROG)
          begin
            d_erase = 1'b1;
            d_er_lo = d_base;
            d_er_hi = d_base + BLK_SIZE;
          end
        end
        else
          d_fail = 1'b1;
      end
      default:
        d_quiet = 1'b1; // other opcodes are not served here, so no reply either
    endcase
  end

  // main sequence: header, optional erase sweep, data, reply
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state_r <= ST_HDR;
    else
    begin
      case (state_r)
        ST_HDR:
          if (hdr_full)
            state_r <= d_erase ? ST_ERASE : (last_seen_r ? ST_REPLY : ST_DATA);
        ST_ERASE:
          if (er_done)
            state_r <= last_seen_r ? ST_REPLY : ST_DATA;
        ST_DATA:
          if (take && link.req_last)
            state_r <= ST_REPLY;
        ST_REPLY:
          if (!fl_wr_r)
            state_r <= quiet_r ? ST_HDR : ST_SEND;
        ST_SEND:
          if (rsp_take && rsp_last_r)
            state_r <= ST_HDR;
        default:
          state_r <= ST_HDR;
      endcase
    end
  end

  // request ready; data bytes are only taken while the flash port is free
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      req_ready_r <= 1'b0;
    else
    begin
      case (state_r)
        ST_HDR:
          if (hdr_full)
            req_ready_r <= !d_erase && !last_seen_r;
          else if (take)
            req_ready_r <= !hdr_slot7 || link.req_last; // hold off while decoding
          else
            req_ready_r <= 1'b1;
        ST_ERASE:
          req_ready_r <= er_done && !last_seen_r;
        ST_DATA:
          if (take)
            req_ready_r <= !link.req_last && !dt_issue;
          else if (fl_wr_r)
            req_ready_r <= fl_ready_in;
          else
            req_ready_r <= 1'b1;
        ST_REPLY:
          req_ready_r <= !fl_wr_r && quiet_r;
        ST_SEND:
          req_ready_r <= rsp_take && rsp_last_r;
        default:
          req_ready_r <= 1'b0;
      endcase
    end
  end

  // frame flags: broadcast is taken from the header bytes, last marks frame end
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bcast_r     <= 1'b0;
      last_seen_r <= 1'b0;
    end
    else
    begin
      if ((state_r == ST_HDR) && take)
        bcast_r <= link.req_bcast;
      if (hdr_clear)
        last_seen_r <= 1'b0;
      else if (take && link.req_last)
        last_seen_r <= 1'b1;
    end
  end

  // command registers loaded from the decode, then walked by erase and data
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ok_r   <= 1'b0;
      fail_r    <= 1'b0;
      quiet_r   <= 1'b0;
      er_addr_r <= '0;
      er_end_r  <= '0;
      wr_addr_r <= '0;
      left_r    <= FIELD_ZERO;
    end
    else if ((state_r == ST_HDR) && hdr_full)
    begin
      wr_ok_r   <= d_wr;
      fail_r    <= d_fail;
      quiet_r   <= d_quiet;
      er_addr_r <= d_er_lo;
      er_end_r  <= d_er_hi;
      wr_addr_r <= d_base + ADDR_W'(h_idx);
      left_r    <= h_cnt;
    end
    else
    begin
      if (er_issue)
        er_addr_r <= er_addr_r + ADDR_W'(1);
      if (dt_issue)
      begin
        wr_addr_r <= wr_addr_r + ADDR_W'(1);
        left_r    <= left_r - 16'h0001;
      end
      // more data than the count announced: the surplus is dropped and flagged
      if ((state_r == ST_DATA) && take && wr_ok_r && (left_r == FIELD_ZERO))
        fail_r <= 1'b1;
    end
  end

  // flash write port, one byte per accepted strobe; erase writes the all-ones byte
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fl_wr_r   <= 1'b0;
      fl_addr_r <= '0;
      fl_data_r <= BYTE_ZERO;
    end
    else if (er_issue)
    begin
      fl_wr_r   <= 1'b1;
      fl_addr_r <= er_addr_r;
      fl_data_r <= ERASED_BYTE;
    end
    else if (dt_issue)
    begin
      fl_wr_r   <= 1'b1;
      fl_addr_r <= wr_addr_r;
      fl_data_r <= link.req_data;
    end
    else if (fl_free)
      fl_wr_r <= 1'b0;
  end

  // reply bytes; a short data stream also counts as failure
  function automatic logic [7:0] reply_byte(input logic [2:0] i);
    case (i)
      3'd0:    reply_byte = h_op | OP_REPLY;
      3'd1:    reply_byte = stat_r;
      3'd2:    reply_byte = h_blk[15:8];
      3'd3:    reply_byte = h_blk[7:0];
      3'd4:    reply_byte = h_idx[15:8];
      3'd5:    reply_byte = h_idx[7:0];
      default: reply_byte = BYTE_ZERO;
    endcase
  endfunction

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stat_r      <= STAT_OK;
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= BYTE_ZERO;
      rsp_last_r  <= 1'b0;
      rsp_idx_r   <= 3'd0;
    end
    else if ((state_r == ST_REPLY) && !fl_wr_r && !quiet_r)
    begin
      stat_r      <= (fail_r || (wr_ok_r && left_r != FIELD_ZERO)) ? STAT_FAIL : STAT_OK;
      rsp_valid_r <= 1'b1;
      rsp_data_r  <= reply_byte(3'd0);
      rsp_last_r  <= 1'b0;
      rsp_idx_r   <= 3'd0;
    end
    else if (rsp_take)
    begin
      rsp_valid_r <= !rsp_last_r;
      rsp_idx_r   <= rsp_idx_r + 3'd1;
      rsp_data_r  <= reply_byte(rsp_idx_r + 3'd1);
      rsp_last_r  <= (rsp_idx_r == 3'd6);
    end
  end

  // busy lags the header by one cycle, harmless since the link is then stalled
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      busy_r <= 1'b0;
    else
      busy_r <= (state_r != ST_HDR) || hdr_full;
  end

  assign link.req_ready = req_ready_r;
  assign link.rsp_valid = rsp_valid_r;
  assign link.rsp_data  = rsp_data_r;
  assign link.rsp_last  = rsp_last_r;
  assign fl_wr_out      = fl_wr_r;
  assign fl_addr_out    = fl_addr_r;
  assign fl_data_out    = fl_data_r;
  assign busy_out       = busy_r;
endmodule

/* File: flash_cmd_pkg.sv */
// How it works
// - clearing leaves every bit of flash at one
// - clear with zero count erases whole store
// - whole-store clear ignores block; host sends zero
// - clear erases whole blocks; start index zero
// - host always sends zero option flags
// - single-block clear carries block size as count
// - clear reply opcode is 0x81 to requester
// - status bit zero set means failure
// - reply echoes block and offset fields unchanged
// - reply count is zero, no payload bytes
// - 0x02 programs, 0x03 clears block then programs
// - clear-then-program erases block before writing data
// - plain program needs target bytes already erased
// - program block index lies within 0..159
// - count equals trailing bytes, written from offset
// - program with zero count erases whole store
// - host keeps offset plus count within block
// - host keeps frame within maximum payload size
// - header is opcode, options, block, offset, count
// - multi-byte fields travel most significant first
// - broadcast requests get no reply at all
package flash_cmd_pkg;
  localparam int          HDR_BYTES    = 8;
  localparam int          HDR_W        = 64;
  localparam int          NUM_BLOCKS   = 160;
  localparam int          BLOCK_BYTES  = 512;
  localparam int          ADDR_W       = 17;
  localparam int          MAX_PAYLOAD  = 256;
  // header field positions, first byte on the wire is the top byte
  localparam int          OPC_LSB      = 56;
  localparam int          OPT_LSB      = 48;
  localparam int          BLK_LSB      = 32;
  localparam int          IDX_LSB      = 16;
  localparam int          CNT_LSB      = 0;
  localparam logic [7:0]  OP_CLEAR     = 8'h01;
  localparam logic [7:0]  OP_PROG      = 8'h02;
  localparam logic [7:0]  OP_CLEAR_PROG = 8'h03;
  localparam logic [7:0]  OP_REPLY     = 8'h80;
  localparam logic [7:0]  OPTIONS_NONE = 8'h00;
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;
  localparam logic [7:0]  STAT_OK      = 8'h00;
  localparam logic [7:0]  STAT_FAIL    = 8'h01;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [15:0] FIELD_ZERO   = 16'h0000;
endpackage

/* File: flash_cmd_if.sv */
`timescale 1ns/1ns
// byte link between requester and flash store, valid/ready on both channels
interface flash_cmd_if;
  logic       req_valid;
  logic [7:0] req_data;
  logic       req_last;
  logic       req_bcast;
  logic       req_ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_last;
  logic       rsp_ready;
  modport dev (
    input  req_valid, req_data, req_last, req_bcast, rsp_ready,
    output req_ready, rsp_valid, rsp_data, rsp_last
  );
  modport host (
    output req_valid, req_data, req_last, req_bcast, rsp_ready,
    input  req_ready, rsp_valid, rsp_data, rsp_last
  );
endinterface

/* File: hdr_capture.sv */
`timescale 1ns/1ns
module hdr_capture #(
  parameter int BYTES = 8
)(
  input  wire logic               core_clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               clear_in,
  input  wire logic               take_in,
  input  wire logic [7:0]         byte_in,
  output logic      [BYTES*8-1:0] hdr_out,
  output logic                    full_out,
  output logic                    slot_last_out
);
  localparam int CW = $clog2(BYTES + 1);

  logic [CW-1:0] cnt_r;

  // shifting in from the bottom puts the first byte on top
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r   <= '0;
      hdr_out <= '0;
    end
    else if (clear_in)
      cnt_r <= '0; // clear wins, a byte in this cycle starts nothing
    else if (take_in && !full_out)
    begin
      hdr_out <= {hdr_out[BYTES*8-9:0], byte_in};
      cnt_r   <= cnt_r + CW'(1);
    end
  end

  assign full_out      = (cnt_r == CW'(BYTES));
  assign slot_last_out = (cnt_r == CW'(BYTES - 1));
endmodule

/* File: flash_host_end.sv */
`timescale 1ns/1ns
module flash_host_end #(
  parameter int NUM_BLOCKS  = flash_cmd_pkg::NUM_BLOCKS,
  parameter int BLOCK_BYTES = flash_cmd_pkg::BLOCK_BYTES,
  parameter int MAX_PAYLOAD = flash_cmd_pkg::MAX_PAYLOAD
)(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  flash_cmd_if.host        link,
  input  wire logic        cmd_go_in,
  input  wire logic [7:0]  cmd_op_in,
  input  wire logic [15:0] cmd_blk_in,
  input  wire logic [15:0] cmd_idx_in,
  input  wire logic [15:0] cmd_cnt_in,
  input  wire logic        cmd_bcast_in,
  input  wire logic        wd_valid_in,
  input  wire logic [7:0]  wd_in,
  output logic             wd_ready_out,
  output logic             busy_out,
  output logic             done_out,
  output logic             refused_out,
  output logic [7:0]       rsp_op_out,
  output logic [7:0]       rsp_status_out,
  output logic [15:0]      rsp_blk_out,
  output logic [15:0]      rsp_idx_out
);
  import flash_cmd_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_HDR, H_DATA, H_WAIT, H_FIN} host_state_type;

  host_state_type   state_r;
  host_state_type   state_nxt;
  logic [HDR_W-1:0] tx_hdr_r;
  logic [2:0]       tx_n_r;
  logic [15:0]      left_r;
  logic             bcast_r;
  logic             req_valid_r;
  logic [7:0]       req_data_r;
  logic             req_last_r;
  logic             wd_ready_r;
  logic             rsp_ready_r;
  logic             done_r;
  logic             refused_r;
  logic             busy_r;
  logic [HDR_W-1:0] rx_hdr;
  logic             is_clear;
  logic             is_prog;
  logic             bad;
  logic             go_ok;
  logic             req_take;
  logic             rsp_take;
  logic [15:0]      n_data;
  logic [HDR_W-1:0] new_hdr;

  hdr_capture #(
    .BYTES         (HDR_BYTES)
  ) u_rx (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .clear_in      (go_ok),
    .take_in       (rsp_take),
    .byte_in       (link.rsp_data),
    .hdr_out       (rx_hdr),
    .full_out      (),
    .slot_last_out ()
  );

  // plain program is passed as given: the caller picks 0x03 unless the span is erased
  assign is_clear = (cmd_op_in == OP_CLEAR);
  assign is_prog  = (cmd_op_in == OP_PROG) || (cmd_op_in == OP_CLEAR_PROG);
  assign bad = !(is_clear || is_prog) ||
               (is_prog && (32'(cmd_blk_in) >= NUM_BLOCKS)) ||
               (is_prog && (17'(cmd_idx_in) + 17'(cmd_cnt_in) > 17'(BLOCK_BYTES))) ||
               (is_prog && (32'(cmd_cnt_in) + HDR_BYTES > MAX_PAYLOAD));
  assign go_ok    = cmd_go_in && (state_r == H_IDLE) && !bad;
  assign req_take = req_valid_r && link.req_ready;
  assign rsp_take = link.rsp_valid && rsp_ready_r;
  assign n_data   = is_prog ? cmd_cnt_in : FIELD_ZERO;

  // header as sent: clear requests get zero offset, whole-store clears zero block, block clears the block size count
  assign new_hdr = {cmd_op_in, OPTIONS_NONE,
                    (is_clear && cmd_cnt_in == FIELD_ZERO) ? FIELD_ZERO : cmd_blk_in,
                    is_clear ? FIELD_ZERO : cmd_idx_in,
                    (is_clear && cmd_cnt_in != FIELD_ZERO) ? 16'(BLOCK_BYTES) : cmd_cnt_in};

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      H_IDLE:
        if (go_ok)
          state_nxt = H_HDR;
      H_HDR:
        if (req_take && tx_n_r == 3'd7)
          state_nxt = (left_r == FIELD_ZERO) ? H_WAIT : H_DATA;
      H_DATA:
        if (req_take && req_last_r)
          state_nxt = H_WAIT;
      H_WAIT:
        if (bcast_r || (rsp_take && link.rsp_last))
          state_nxt = H_FIN;
      H_FIN:
        state_nxt = H_IDLE;
      default:
        state_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= H_IDLE;
      busy_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      busy_r  <= (state_nxt != H_IDLE);
    end
  end

  // request byte stream: eight header bytes most significant first, then data
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      req_valid_r <= 1'b0;
      req_data_r  <= BYTE_ZERO;
      req_last_r  <= 1'b0;
      tx_hdr_r    <= '0;
      tx_n_r      <= 3'd0;
      left_r      <= FIELD_ZERO;
      bcast_r     <= 1'b0;
      wd_ready_r  <= 1'b0;
    end
    else if (go_ok)
    begin
      req_valid_r <= 1'b1;
      req_data_r  <= new_hdr[OPC_LSB +: 8];
      req_last_r  <= 1'b0;
      tx_hdr_r    <= {new_hdr[HDR_W-9:0], BYTE_ZERO};
      tx_n_r      <= 3'd0;
      left_r      <= n_data;
      bcast_r     <= cmd_bcast_in;
    end
    else if ((state_r == H_HDR) && req_take)
    begin
      req_valid_r <= (tx_n_r != 3'd7);
      req_data_r  <= tx_hdr_r[OPC_LSB +: 8];
      req_last_r  <= (tx_n_r == 3'd6) && (left_r == FIELD_ZERO);
      tx_hdr_r    <= {tx_hdr_r[HDR_W-9:0], BYTE_ZERO};
      tx_n_r      <= tx_n_r + 3'd1;
    end
    else if (state_r == H_DATA)
    begin
      // one byte in flight at a time keeps the user side free of skid storage
      if (wd_valid_in && wd_ready_r)
      begin
        req_valid_r <= 1'b1;
        req_data_r  <= wd_in;
        req_last_r  <= (left_r == 16'h0001);
        left_r      <= left_r - 16'h0001;
        wd_ready_r  <= 1'b0;
      end
      else if (req_take)
        req_valid_r <= 1'b0;
      else if (!req_valid_r && left_r != FIELD_ZERO)
        wd_ready_r <= 1'b1;
    end
  end

  // reply side and completion reporting
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rsp_ready_r <= 1'b0;
      done_r      <= 1'b0;
      refused_r   <= 1'b0;
    end
    else
    begin
      rsp_ready_r <= (state_r == H_WAIT) && !bcast_r && !(rsp_take && link.rsp_last);
      done_r      <= (state_r == H_FIN) || (cmd_go_in && state_r == H_IDLE && bad);
      if (cmd_go_in && state_r == H_IDLE)
        refused_r <= bad;
    end
  end

  assign link.req_valid = req_valid_r;
  assign link.req_data  = req_data_r;
  assign link.req_last  = req_last_r;
  assign link.req_bcast = bcast_r;
  assign link.rsp_ready = rsp_ready_r;
  assign wd_ready_out   = wd_ready_r;
  assign busy_out       = busy_r;
  assign done_out       = done_r;
  assign refused_out    = refused_r;
  assign rsp_op_out     = rx_hdr[OPC_LSB +: 8];
  assign rsp_status_out = rx_hdr[OPT_LSB +: 8];
  assign rsp_blk_out    = rx_hdr[BLK_LSB +: 16];
  assign rsp_idx_out    = rx_hdr[IDX_LSB +: 16];
endmodule

/* File: flash_cmd_assertions.sv */
`timescale 1ns/1ns
module flash_cmd_assertions (
  input wire logic       core_clk_in,
  input wire logic       rst_n_in,
  input wire logic       req_valid,
  input wire logic [7:0] req_data,
  input wire logic       req_last,
  input wire logic       req_bcast,
  input wire logic       req_ready,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic       rsp_last,
  input wire logic       rsp_ready
);
  logic [7:0] hb [8];
  logic [3:0] qn_r;
  logic [2:0] rn_r;
  logic       bc_r;
  // header bytes kept so the reply can be held against the request
  always_ff @(posedge core_clk_in)
  begin
    if (req_valid && req_ready && qn_r < 4'h8)
      hb[qn_r[2:0]] <= req_data;
  end
  // request byte position, saturates past the header
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      qn_r <= 4'h0;
    else if (req_valid && req_ready)
      qn_r <= req_last ? 4'h0 : qn_r + {3'h0, qn_r < 4'h8};
  end
  // broadcast flag of the latest frame
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      bc_r <= 1'b0;
    else if (req_valid && req_ready && qn_r == 4'h0)
      bc_r <= req_bcast;
  end
  // reply byte position
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rn_r <= 3'h0;
    else if (rsp_valid && rsp_ready)
      rn_r <= rsp_last ? 3'h0 : rn_r + 3'h1;
  end
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_wait;
    rsp_valid && !rsp_ready;
  endsequence
  sequence s_end;
    rsp_valid && rsp_ready && rsp_last;
  endsequence
  a_rsp_hold: assert property (s_wait |=> rsp_valid && $stable(rsp_data))
    else $error("reply byte dropped");
  a_reply_op: assert property (rsp_valid && rn_r == 3'h0 |->
    rsp_data == (hb[0] | 8'h80) && hb[0] inside {8'h01, 8'h02, 8'h03})
    else $error("reply opcode wrong");
  a_status_bits: assert property (rsp_valid && rn_r == 3'h1 |-> rsp_data[7:1] == 7'h00)
    else $error("reserved status bits set");
  a_echo_fields: assert property (rsp_valid && rn_r inside {[3'h2:3'h5]} |->
    rsp_data == hb[rn_r])
    else $error("reply echo wrong");
  a_count_zero: assert property (rsp_valid && rn_r[2:1] == 2'h3 |-> rsp_data == 8'h00)
    else $error("reply count not zero");
  a_last_eighth: assert property (rsp_valid |-> rsp_last == (rn_r == 3'h7))
    else $error("reply length wrong");
  a_bcast_quiet: assert property (bc_r |-> !rsp_valid)
    else $error("reply to broadcast");
  a_ready_back: assert property (s_end |=> req_ready)
    else $error("request link not reopened");
endmodule

/* File: test_flash_block_erase_write_cmd.sv */
`timescale 1ns/1ns
module test_flash_block_erase_write_cmd;
  localparam int NB = 4;
  localparam int BB = 16;
  logic        clk = 1'b0, rst_n = 1'b0, go = 1'b0, bc = 1'b0, wv = 1'b0, frdy = 1'b0;
  logic [7:0]  op = 8'h00, wd = 8'h00, r_op, r_st, fdat, wdat[$];
  logic [15:0] blk = 16'h0000, idx = 16'h0000, cnt = 16'h0000, r_blk, r_idx;
  logic [6:0]  fadr, wa[$];
  logic [1:0]  cyc = 2'h0;
  logic        fwr, wrdy, dbusy, hbusy, done, refd;
  int          n_mismatch = 0, total_checks = 0;
  flash_cmd_if lk ();
  // the address must reach the store size itself, so 64 bytes need seven bits
  flash_dev_end #(.NUM_BLOCKS(NB), .BLOCK_BYTES(BB), .ADDR_W(7)) i_flash_dev_end (
    .core_clk_in(clk), .rst_n_in(rst_n), .link(lk), .fl_wr_out(fwr), .fl_addr_out(fadr),
    .fl_data_out(fdat), .fl_ready_in(frdy), .busy_out(dbusy));
  flash_host_end #(.NUM_BLOCKS(NB), .BLOCK_BYTES(BB)) i_flash_host_end (
    .core_clk_in(clk), .rst_n_in(rst_n), .link(lk), .cmd_go_in(go), .cmd_op_in(op),
    .cmd_blk_in(blk), .cmd_idx_in(idx), .cmd_cnt_in(cnt), .cmd_bcast_in(bc), .wd_valid_in(wv),
    .wd_in(wd), .wd_ready_out(wrdy), .busy_out(hbusy), .done_out(done), .refused_out(refd),
    .rsp_op_out(r_op), .rsp_status_out(r_st), .rsp_blk_out(r_blk), .rsp_idx_out(r_idx));
  flash_cmd_assertions chk (.core_clk_in(clk), .rst_n_in(rst_n), .req_valid(lk.req_valid),
    .req_data(lk.req_data), .req_last(lk.req_last), .req_bcast(lk.req_bcast),
    .req_ready(lk.req_ready), .rsp_valid(lk.rsp_valid), .rsp_data(lk.rsp_data),
    .rsp_last(lk.rsp_last), .rsp_ready(lk.rsp_ready));
  always #5 clk = ~clk;
  // flash stalls one cycle in four so held writes get exercised
  always @(posedge clk)
  begin
    cyc <= cyc + 2'h1;
    frdy <= cyc != 2'h3;
    if (fwr && frdy)
    begin
      wa.push_back(fadr);
      wdat.push_back(fdat);
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // md: 0 unicast, 1 broadcast, 2 refused by host; erase span then data span
  task automatic xfer(input logic [7:0] o, input int b, i, c, md, eb, en, db, dn,
                      input logic [7:0] st);
    int t;
    int k;
    wa.delete();
    wdat.delete();
    @(posedge clk);
    go <= 1'b1;
    op <= o;
    blk <= 16'(b);
    idx <= 16'(i);
    cnt <= 16'(c);
    bc <= md == 1;
    wv <= dn > 0;
    wd <= 8'ha0;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    for (t = 0; t < 3000 && done !== 1'b1; t++)
    begin
      @(posedge clk);
      if (wv && wrdy)
      begin
        k++;
        wd <= 8'ha0 + 8'(k);
        wv <= k < dn;
      end
    end
    for (k = 0; k < 3000 && dbusy !== 1'b0; k++)
      @(posedge clk);
    if (t >= 3000 || k >= 3000)
    begin
      n_mismatch++;
      conclude();
    end
    check(16'(refd), 16'(md == 2));
    check(16'(hbusy), 16'h0000);
    if (md == 0)
    begin
      check({r_op, r_st}, {o | 8'h80, st});
      check(r_blk, (o == 8'h01 && c == 0) ? 16'h0000 : 16'(b));
      check(r_idx, (o == 8'h01) ? 16'h0000 : 16'(i));
    end
    check(16'(wa.size()), 16'(en + dn));
    for (k = 0; k < en + dn; k++)
      check({1'h0, wa[k], wdat[k]}, (k < en) ? {1'h0, 7'(eb + k), 8'hff}
            : {1'h0, 7'(db + k - en), 8'ha0 + 8'(k - en)});
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    xfer(8'h01, 3, 0, 0, 0, 0, NB * BB, 0, 0, 8'h00);
    xfer(8'h01, 2, 5, BB, 0, 2 * BB, BB, 0, 0, 8'h00);
    xfer(8'h02, 1, 3, 2, 0, 0, 0, BB + 3, 2, 8'h00);
    xfer(8'h03, 3, BB - 2, 2, 0, 3 * BB, BB, 4 * BB - 2, 2, 8'h00);
    xfer(8'h02, 1, 0, 0, 0, 0, NB * BB, 0, 0, 8'h00);
    xfer(8'h01, NB, 0, BB, 0, 0, 0, 0, 0, 8'h01);
    xfer(8'h02, NB, 0, 1, 2, 0, 0, 0, 0, 8'h00);
    xfer(8'h07, 0, 0, 0, 2, 0, 0, 0, 0, 8'h00);
    xfer(8'h01, 1, 0, BB, 1, BB, BB, 0, 0, 8'h00);
    conclude();
  end
endmodule
